// ---- src/event_fifo.sv ----
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module event_fifo #(
  parameter int WIDTH = latch_driver_pkg::EV_W,
  parameter int DEPTH = latch_driver_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  // filling side
  event_if.sink in_port,
  // draining side
  event_if.source out_port
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  // honest full and empty
  assign in_port.ready = (count != (AW+1)'(DEPTH));
  assign out_port.valid = (count != '0);
  assign out_port.data = mem[rd_ptr];
  assign push = in_port.valid && in_port.ready;
  assign pop = out_port.valid && out_port.ready;

  // pointer and count update
  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (flush)
    begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
    end
    else
    begin
      if (push)
        next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      if (push && !pop)
        next_count = count + 1'b1;
      else if (pop && !push)
        next_count = count - 1'b1;
    end
  end

  // pointer registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage array, written on push only
  always_ff @(posedge clk)
  begin
    if (push && !flush)
      mem[wr_ptr] <= in_port.data;
  end
endmodule // event_fifo

// ---- src/event_if.sv ----
// valid/ready carrier for pin events between sampler, fifo and core
`timescale 1ns/1ps
interface event_if #(
  parameter int WIDTH = latch_driver_pkg::EV_W
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  // producer drives valid and data
  modport source (
    output valid,
    output data,
    input ready
  );

  // consumer drives ready
  modport sink (
    input valid,
    input data,
    output ready
  );
endinterface

// ---- src/latch_driver_pkg.sv ----
// constants and types shared by the serial latch driver design
//
// Notes on behaviour
// - shift on shift_clk rise, copy on latch_clk rise
// - storage reaches outputs only while clear_n high
// - clear_n low zeroes chain, storage, outputs
// - output enable high forces every channel off
// - output enable low: channels follow storage bits
// - channel zero is off, one sinks current
// - serial_dout updates from last stage on fall
// - input bit reaches serial_dout after 7.5 periods
package latch_driver_pkg;

  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int CHAIN_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int EV_W = 3;
  localparam int PIN_W = 5;

  // ----------------------------------------------------------------
  // positions of the pins in the sampled pin vector
  // ----------------------------------------------------------------
  localparam int PIN_SHIFT = 0;
  localparam int PIN_LATCH = 1;
  localparam int PIN_DIN = 2;
  localparam int PIN_CLEAR = 3;
  localparam int PIN_OE = 4;
  // safe idle level: clear asserted, output enable off
  localparam logic [4:0] PIN_IDLE = 5'h10;

  // ----------------------------------------------------------------
  // event word: kind in the upper bits, serial bit in bit 0
  // ----------------------------------------------------------------
  localparam int EV_BIT = 0;
  localparam int EV_KIND_LO = 1;
  localparam logic [1:0] EV_SHIFT_RISE = 2'h1;
  localparam logic [1:0] EV_SHIFT_FALL = 2'h2;
  localparam logic [1:0] EV_LATCH_RISE = 2'h3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CHAIN_RESET = 8'h00;
  localparam logic [7:0] CHANNELS_OFF = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_PERIOD_NS = 25;
  localparam int LATCH_SETUP_NS = 200;
  localparam int LATCH_SETUP_CYC =
    (LATCH_SETUP_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // core sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_COMMIT = 2'b10
  } core_state_e;

endpackage

// ---- src/serial_latch_driver.sv ----
// serial-in, parallel-out latch driver with eight low-side channels
`timescale 1ns/1ps
module serial_latch_driver #(
  parameter int CHAIN_W = latch_driver_pkg::CHAIN_W,
  parameter int DEPTH = latch_driver_pkg::FIFO_DEPTH
) (
  // core clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // serial pins from the host
  input wire logic SHIFT_CLK,
  input wire logic LATCH_CLK,
  input wire logic SERIAL_DIN,
  input wire logic CLEAR_N,
  input wire logic OUTPUT_EN_N,
  // cascade output
  output logic SERIAL_DOUT,
  // drain switch controls, one turns the switch on
  output logic [CHAIN_W-1:0] CHANNEL_OUT,
  // event lost because the fifo was full
  output logic EVENT_OVERRUN
);

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  logic [4:0] pins;
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  logic [4:0] filt;
  logic [4:0] prev;
  logic [4:0] next_filt;

  assign pins = {OUTPUT_EN_N, CLEAR_N, SERIAL_DIN, LATCH_CLK, SHIFT_CLK};

  // a pin change counts once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < latch_driver_pkg::PIN_W; gi++)
    begin : g_filter
      assign next_filt[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi]
                                                       : filt[gi];
    end
  endgenerate

  // three-stage synchroniser and filtered level
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      sync1 <= latch_driver_pkg::PIN_IDLE;
      sync2 <= latch_driver_pkg::PIN_IDLE;
      sync3 <= latch_driver_pkg::PIN_IDLE;
      filt <= latch_driver_pkg::PIN_IDLE;
      prev <= latch_driver_pkg::PIN_IDLE;
    end
    else
    begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
      prev <= filt;
    end
  end

  // ----------------------------------------------------------------
  // edge detection and event generation
  // ----------------------------------------------------------------
  logic clear_ok;
  logic oe_n;
  logic shift_rise;
  logic shift_fall;
  logic latch_rise;
  logic latch_pend;
  logic next_latch_pend;
  logic overrun;
  logic next_overrun;

  assign clear_ok = filt[latch_driver_pkg::PIN_CLEAR];
  assign oe_n = filt[latch_driver_pkg::PIN_OE];
  assign shift_rise = filt[latch_driver_pkg::PIN_SHIFT]
                    && !prev[latch_driver_pkg::PIN_SHIFT];
  assign shift_fall = !filt[latch_driver_pkg::PIN_SHIFT]
                    && prev[latch_driver_pkg::PIN_SHIFT];
  assign latch_rise = filt[latch_driver_pkg::PIN_LATCH]
                    && !prev[latch_driver_pkg::PIN_LATCH];

  event_if #(.WIDTH(latch_driver_pkg::EV_W)) ev_in ();
  event_if #(.WIDTH(latch_driver_pkg::EV_W)) ev_out ();

  // shift edges go first; a latch edge in the same cycle waits one
  always_comb
  begin
    ev_in.valid = 1'b0;
    ev_in.data = '0;
    next_latch_pend = latch_pend;
    next_overrun = overrun;
    if (!clear_ok)
    begin
      next_latch_pend = 1'b0;
      next_overrun = 1'b0;
    end
    else
    begin
      if (shift_rise)
      begin
        ev_in.valid = 1'b1;
        ev_in.data = {latch_driver_pkg::EV_SHIFT_RISE,
                      filt[latch_driver_pkg::PIN_DIN]};
      end
      else if (shift_fall)
      begin
        ev_in.valid = 1'b1;
        ev_in.data = {latch_driver_pkg::EV_SHIFT_FALL, 1'b0};
      end
      else if (latch_rise || latch_pend)
      begin
        ev_in.valid = 1'b1;
        ev_in.data = {latch_driver_pkg::EV_LATCH_RISE, 1'b0};
      end
      // host spacing keeps a pended latch clear of the next shift
      if (latch_rise && (shift_rise || shift_fall))
        next_latch_pend = 1'b1;
      else if (ev_in.valid && ev_in.ready)
        next_latch_pend = 1'b0;
      if (ev_in.valid && !ev_in.ready)
        next_overrun = 1'b1;
    end
  end

  // event generation registers
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      latch_pend <= 1'b0;
      overrun <= 1'b0;
    end
    else
    begin
      latch_pend <= next_latch_pend;
      overrun <= next_overrun;
    end
  end

  // ----------------------------------------------------------------
  // event buffer
  // ----------------------------------------------------------------
  event_fifo #(
    .WIDTH(latch_driver_pkg::EV_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(CORE_CLK),
    .rst(RESET),
    .flush(!clear_ok),
    .in_port(ev_in.sink),
    .out_port(ev_out.source)
  );

  // ----------------------------------------------------------------
  // shift chain, storage and cascade output
  // ----------------------------------------------------------------
  latch_driver_pkg::core_state_e state;
  latch_driver_pkg::core_state_e next_state;
  logic [CHAIN_W-1:0] chain;
  logic [CHAIN_W-1:0] storage;
  logic [CHAIN_W-1:0] next_chain;
  logic [CHAIN_W-1:0] next_storage;
  logic [1:0] ev_kind;
  logic ev_bit;
  logic take;
  logic next_dout;

  assign ev_kind = ev_out.data[latch_driver_pkg::EV_KIND_LO +: 2];
  assign ev_bit = ev_out.data[latch_driver_pkg::EV_BIT];
  // the core stalls for one cycle after each commit
  assign ev_out.ready = (state == latch_driver_pkg::ST_RUN);
  assign take = ev_out.valid && ev_out.ready;

  // apply one event per cycle
  always_comb
  begin
    next_state = state;
    next_chain = chain;
    next_storage = storage;
    next_dout = SERIAL_DOUT;
    if (!clear_ok)
    begin
      next_state = latch_driver_pkg::ST_RUN;
      next_chain = latch_driver_pkg::CHAIN_RESET;
      next_storage = latch_driver_pkg::CHAIN_RESET;
      next_dout = 1'b0;
    end
    else
    begin
      case (state)
        latch_driver_pkg::ST_RUN:
        begin
          if (take && ev_kind == latch_driver_pkg::EV_SHIFT_RISE)
            next_chain = {chain[CHAIN_W-2:0], ev_bit};
          else if (take && ev_kind == latch_driver_pkg::EV_SHIFT_FALL)
            next_dout = chain[CHAIN_W-1];
          else if (take && ev_kind == latch_driver_pkg::EV_LATCH_RISE)
          begin
            next_storage = chain;
            next_state = latch_driver_pkg::ST_COMMIT;
          end
        end
        latch_driver_pkg::ST_COMMIT:
          next_state = latch_driver_pkg::ST_RUN;
        default:
          next_state = latch_driver_pkg::ST_RUN;
      endcase
    end
  end

  // core registers
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      state <= latch_driver_pkg::ST_RUN;
      chain <= latch_driver_pkg::CHAIN_RESET;
      storage <= latch_driver_pkg::CHAIN_RESET;
      SERIAL_DOUT <= 1'b0;
    end
    else
    begin
      state <= next_state;
      chain <= next_chain;
      storage <= next_storage;
      SERIAL_DOUT <= next_dout;
    end
  end

  // ----------------------------------------------------------------
  // output buffers
  // ----------------------------------------------------------------
  logic [CHAIN_W-1:0] next_channels;

  // gate storage by clear and output enable
  always_comb
  begin
    if (!clear_ok)
      next_channels = latch_driver_pkg::CHANNELS_OFF;
    else if (oe_n)
      next_channels = latch_driver_pkg::CHANNELS_OFF;
    else
      next_channels = storage;
  end

  // output registers
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      CHANNEL_OUT <= latch_driver_pkg::CHANNELS_OFF;
      EVENT_OVERRUN <= 1'b0;
    end
    else
    begin
      CHANNEL_OUT <= next_channels;
      EVENT_OVERRUN <= overrun;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);

  sequence s_take_rise;
    take && clear_ok && ev_kind == latch_driver_pkg::EV_SHIFT_RISE;
  endsequence

  sequence s_take_fall;
    take && clear_ok && ev_kind == latch_driver_pkg::EV_SHIFT_FALL;
  endsequence

  sequence s_take_latch;
    take && clear_ok && ev_kind == latch_driver_pkg::EV_LATCH_RISE;
  endsequence

  a_shift_advance: assert property (
    s_take_rise |=> chain[CHAIN_W-1:1] == $past(chain[CHAIN_W-2:0]))
    else $error("shift chain did not advance");

  a_first_stage: assert property (
    s_take_rise |=> chain[0] == $past(ev_bit))
    else $error("serial input not in first stage");

  a_latch_copy: assert property (
    s_take_latch ##1 clear_ok |-> storage == $past(chain))
    else $error("storage did not copy shift chain");

  a_clear_zero: assert property (
    !clear_ok |=> chain == '0 && storage == '0 && !SERIAL_DOUT)
    else $error("clear did not zero registers");

  a_clear_outputs: assert property (
    !clear_ok |=> CHANNEL_OUT == latch_driver_pkg::CHANNELS_OFF)
    else $error("channels on while clear low");

  a_enable_off: assert property (
    oe_n |=> CHANNEL_OUT == latch_driver_pkg::CHANNELS_OFF)
    else $error("channels on while enable high");

  a_enable_follow: assert property (
    !oe_n && clear_ok |=> CHANNEL_OUT == $past(storage))
    else $error("channels do not follow storage");

  a_dout_fall: assert property (
    s_take_fall ##1 clear_ok |-> SERIAL_DOUT == $past(chain[CHAIN_W-1]))
    else $error("serial output not from last stage");

  a_dout_hold: assert property (
    s_take_rise ##1 clear_ok |-> $stable(SERIAL_DOUT))
    else $error("serial output moved on rising edge");

endmodule // serial_latch_driver

// ---- testbench/host_model.sv ----
// host model pacing the serial pins of the latch driver
`timescale 1ns/1ps
module host_model #(
  parameter int HOLD = 8
) (
  // core clock used to pace the pins
  input wire logic clk,
  // serial pins toward the device
  output logic shift_clk,
  output logic latch_clk,
  output logic serial_din,
  output logic clear_n,
  output logic output_en_n
);
  // ----------------------------------------------------------------
  // pin sequencing
  // ----------------------------------------------------------------
  // safe levels at time zero: cleared, outputs off
  initial
  begin
    shift_clk = 1'h0;
    latch_clk = 1'h0;
    serial_din = 1'h0;
    clear_n = 1'h0;
    output_en_n = 1'h1;
  end

  // each level stands long enough for the pin filter
  task automatic pause(input int n);
    repeat (n) @(negedge clk);
  endtask

  // data set up, then shift clock rises and stays high
  task automatic rise(input logic bit_v);
    serial_din = bit_v;
    pause(HOLD);
    shift_clk = 1'h1;
    pause(HOLD);
  endtask

  // shift clock falls; data no longer held, so show its inverse
  task automatic fall();
    shift_clk = 1'h0;
    serial_din = ~serial_din;
    pause(HOLD);
  endtask

  // latch rise kept clear of the last shift rise by the setup gap
  task automatic latch();
    pause(latch_driver_pkg::LATCH_SETUP_CYC);
    latch_clk = 1'h1;
    pause(HOLD);
    latch_clk = 1'h0;
    pause(HOLD);
  endtask

  // clear and output enable levels
  task automatic levels(input logic clear_lvl, input logic oe_n);
    clear_n = clear_lvl;
    output_en_n = oe_n;
    pause(HOLD);
  endtask

  // power-up: pulse clear low, then release with outputs enabled
  task automatic init();
    levels(1'h0, 1'h1);
    levels(1'h1, 1'h0);
  endtask
endmodule // host_model

// ---- testbench/serial_in_parallel_out_latch_driver_tb.sv ----
// self-checking bench for the serial latch driver
`timescale 1ns/1ps
module serial_in_parallel_out_latch_driver_tb;
  // ----------------------------------------------------------------
  // clock, reset and wiring
  // ----------------------------------------------------------------
  logic core_clk = 1'h0;
  logic reset = 1'h1;
  logic shift_clk;
  logic latch_clk;
  logic serial_din;
  logic clear_n;
  logic output_en_n;
  logic serial_dout;
  logic [7:0] channel_out;
  logic event_overrun;
  logic [7:0] chain = 8'h00;
  logic dout_exp = 1'h0;
  int fail_count = 0;
  int tests_run = 0;

  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;

  serial_latch_driver serial_latch_driver_i (
    .CORE_CLK(core_clk),
    .RESET(reset),
    .SHIFT_CLK(shift_clk),
    .LATCH_CLK(latch_clk),
    .SERIAL_DIN(serial_din),
    .CLEAR_N(clear_n),
    .OUTPUT_EN_N(output_en_n),
    .SERIAL_DOUT(serial_dout),
    .CHANNEL_OUT(channel_out),
    .EVENT_OVERRUN(event_overrun)
  );

  host_model host_model_i (
    .clk(core_clk),
    .shift_clk(shift_clk),
    .latch_clk(latch_clk),
    .serial_din(serial_din),
    .clear_n(clear_n),
    .output_en_n(output_en_n)
  );

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  // compare one value against its expectation
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  // print counts and verdict, then stop
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one bit: serial output stands at the rise, moves at the fall
  task automatic shift_bit(input logic b);
    host_model_i.rise(b);
    check({7'h00, serial_dout}, {7'h00, dout_exp}, "dout at rise");
    chain = {chain[6:0], b};
    host_model_i.fall();
    dout_exp = chain[7];
    check({7'h00, serial_dout}, {7'h00, dout_exp}, "dout at fall");
  endtask

  // whole byte, first bit shifted is bit 7
  task automatic shift_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      shift_bit(v[i]);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // outputs quiet after reset, then the host clears the device
  task automatic test_reset();
    @(negedge core_clk);
    check(channel_out, 8'h00, "channels after reset");
    check({7'h00, serial_dout}, 8'h00, "dout after reset");
    host_model_i.init();
    check(channel_out, 8'h00, "channels after clear");
    $display("test_reset done");
  endtask

  // shifting alone leaves channels; the latch commits the chain
  task automatic test_load();
    shift_byte(8'ha5);
    check(channel_out, 8'h00, "channels before latch");
    host_model_i.latch();
    check(channel_out, 8'ha5, "channels after latch");
    $display("test_load done");
  endtask

  // enable high forces all channels off, low restores storage
  task automatic test_enable();
    host_model_i.levels(1'h1, 1'h1);
    check(channel_out, 8'h00, "channels disabled");
    host_model_i.levels(1'h1, 1'h0);
    check(channel_out, 8'ha5, "channels enabled");
    $display("test_enable done");
  endtask

  // old byte cascades out while a new one shifts in, then commits
  task automatic test_cascade();
    shift_byte(8'h3c);
    check(channel_out, 8'ha5, "channels hold");
    host_model_i.latch();
    check(channel_out, 8'h3c, "channels second load");
    $display("test_cascade done");
  endtask

  // clear empties everything and blocks a latch while low
  task automatic test_clear();
    host_model_i.levels(1'h0, 1'h0);
    check(channel_out, 8'h00, "channels in clear");
    check({7'h00, serial_dout}, 8'h00, "dout in clear");
    host_model_i.latch();
    check(channel_out, 8'h00, "latch in clear");
    host_model_i.levels(1'h1, 1'h0);
    chain = 8'h00;
    dout_exp = 1'h0;
    host_model_i.latch();
    check(channel_out, 8'h00, "chain was cleared");
    shift_byte(8'h81);
    host_model_i.latch();
    check(channel_out, 8'h81, "load after clear");
    // legal host pacing never outruns the event queue
    check({7'h00, event_overrun}, 8'h00, "no overrun");
    $display("test_clear done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  // reset held five cycles, inputs moved on the falling edge
  initial
  begin
    repeat (5) @(negedge core_clk);
    reset = 1'h0;
    test_reset();
    test_load();
    test_enable();
    test_cascade();
    test_clear();
    end_sim();
  end

  // the run needs about 750 cycles; cut a hang short
  initial
  begin
    repeat (10000) @(posedge core_clk);
    fail_count++;
    end_sim();
  end
endmodule // serial_in_parallel_out_latch_driver_tb
